// ---- pcm_partner_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcm_partner_model (
    input  wire logic        msb_first_i,
    input  wire logic [15:0] rx_word_i,
    input  wire logic        tx_line_i,
    output logic             bit_clk_o,
    output logic             sync_n_o,
    output logic             rx_line_o,
    output logic      [15:0] tx_word_o,
    output logic      [7:0]  frames_o
);
    logic [15:0] shift;
    // A 488 ns bit clock, offset so that it never meets a system clock edge.
    initial begin
        bit_clk_o = 1'b0;
        #2;
        forever #244 bit_clk_o = ~bit_clk_o;
    end
    // Sync moves only on rising bit clock edges and recurs every 256 of them.
    initial begin
        sync_n_o  = 1'b1;
        rx_line_o = 1'b0;
        tx_word_o = 16'h0000;
        frames_o  = 8'h00;
        forever begin
            @(posedge bit_clk_o);
            sync_n_o <= 1'b0;
            @(negedge bit_clk_o);
            for (int i = 0; i < 16; i++) begin
                @(posedge bit_clk_o);
                if (i == 1) sync_n_o <= 1'b1;
                rx_line_o <= rx_word_i[msb_first_i ? 15 - i : i];
                @(negedge bit_clk_o);
                shift[msb_first_i ? 15 - i : i] = tx_line_i;
            end
            @(posedge bit_clk_o);
            // The released line shows the inverse of its last bit.
            rx_line_o <= ~rx_line_o;
            tx_word_o <= shift;
            frames_o  <= frames_o + 8'h01;
            repeat (238) @(posedge bit_clk_o);
        end
    end
endmodule
`default_nettype wire

// ---- pcm_serial_pkg.sv ----
// Function
// - Transmit shifts out one 16-bit two's complement word each frame.
// - Receive takes one 16-bit two's complement word each frame from the partner.
// - Bit order select high means MSB first on both paths, low LSB first.
// - Transmit output is high impedance whenever no word is being shifted.
// - Falling transmit sync starts a 16-bit transfer out of the transmit pin.
// - Falling receive sync starts capture of 16 bits from the receive pin.
// - Each path's master clock runs at 2.048 MHz, one bit clock per path.
// - Sample rate is 8 kHz, one word per path per sample period.
// - Disable input high powers the device down; low means normal operation.
// - Receive gain select high gives +3 dB, low gives 0 dB.
// - Transmit gain select high gives -3 dB, low 0 dB; tied low-supply bypasses filter.
// - Word operation starts on first falling data clock edge after sync goes low.
// - Each path works on its own sync and its own clock, independently of the other.
package pcm_serial_pkg;

    localparam int unsigned WORD_BITS       = 16;
    localparam int unsigned CNT_W           = 5;
    localparam logic [4:0]  LAST_BIT_COUNT  = 5'h10;
    localparam logic [4:0]  LAST_RX_INDEX   = 5'h0f;
    localparam int unsigned FRAME_CLOCKS    = 256;
    localparam int unsigned FRAME_W         = 9;
    localparam logic [8:0]  FRAME_COUNT_OK  = 9'h100;
    localparam int unsigned BIT_CLOCK_KHZ   = 2048;
    localparam int unsigned SAMPLE_RATE_HZ  = 8000;
    localparam int unsigned FIFO_DEPTH      = 4;
    localparam logic [15:0] IDLE_WORD       = 16'h0000;
    localparam logic [4:0]  COUNT_RESET     = 5'h00;
    localparam logic [8:0]  FRAME_RESET     = 9'h000;

    typedef enum logic [1:0] {
        PATH_IDLE   = 2'b00,
        PATH_ARMED  = 2'b01,
        PATH_LOADED = 2'b10,
        PATH_SHIFT  = 2'b11
    } path_state_e;

    // Picks the wire-order bit at position idx of a word.
    function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic msb_first);
        bit_pos = msb_first ? (4'hf - idx[3:0]) : idx[3:0];
    endfunction

endpackage

// ---- pcm_serial_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcm_serial_port #(
    parameter int unsigned WORD_W = pcm_serial_pkg::WORD_BITS,
    parameter int unsigned DEPTH  = pcm_serial_pkg::FIFO_DEPTH
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              tx_master_clock_i,
    input  wire logic              tx_frame_sync_n_i,
    output logic                   tx_serial_out_o,
    output logic                   tx_serial_oe_o,
    input  wire logic              rx_master_clock_i,
    input  wire logic              rx_frame_sync_n_i,
    input  wire logic              rx_serial_in_i,
    input  wire logic              bit_order_select_i,
    input  wire logic              power_down_in_i,
    input  wire logic              tx_gain_select_i,
    input  wire logic              tx_filter_bypass_i,
    input  wire logic              rx_gain_select_i,
    input  wire logic [WORD_W-1:0] tx_sample_i,
    input  wire logic              tx_sample_valid_i,
    output logic                   tx_sample_ready_o,
    output logic      [WORD_W-1:0] rx_sample_o,
    output logic                   rx_sample_valid_o,
    input  wire logic              rx_sample_ready_i,
    output logic                   tx_active_o,
    output logic                   rx_active_o,
    output logic                   powered_down_o,
    output logic                   rx_gain_plus3_o,
    output logic                   tx_gain_minus3_o,
    output logic                   tx_filter_bypassed_o,
    output logic                   tx_underrun_o,
    output logic                   rx_overrun_o,
    output logic                   frame_error_o
);
    pcm_serial_pkg::path_state_e tx_state;
    pcm_serial_pkg::path_state_e rx_state;

    logic              tx_clk_prev;
    logic              rx_clk_prev;
    logic              tx_sync_prev;
    logic              rx_sync_prev;
    logic              tx_rise;
    logic              tx_fall;
    logic              rx_fall;
    logic              tx_sync_fall;
    logic              rx_sync_fall;
    logic [4:0]        tx_count;
    logic [4:0]        rx_count;
    logic [WORD_W-1:0] tx_word;
    logic [WORD_W-1:0] rx_word;
    logic [WORD_W-1:0] next_rx_word;
    logic              tx_msb_first;
    logic              rx_msb_first;
    logic [WORD_W-1:0] tx_fifo_data;
    logic              tx_fifo_valid;
    logic              tx_fifo_pop;
    logic              rx_push;
    logic              rx_fifo_ready;
    logic [8:0]        frame_clocks;
    logic              frame_seen;

    assign tx_rise      = tx_master_clock_i && !tx_clk_prev;
    assign tx_fall      = !tx_master_clock_i && tx_clk_prev;
    assign rx_fall      = !rx_master_clock_i && rx_clk_prev;
    assign tx_sync_fall = tx_sync_prev && !tx_frame_sync_n_i;
    assign rx_sync_fall = rx_sync_prev && !rx_frame_sync_n_i;
    // Edge A of the transmit path takes the next queued sample.
    assign tx_fifo_pop  = !power_down_in_i && (tx_state == pcm_serial_pkg::PATH_ARMED) && tx_fall;

    sample_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (tx_sample_i),
        .in_valid_i  (tx_sample_valid_i),
        .in_ready_o  (tx_sample_ready_o),
        .out_data_o  (tx_fifo_data),
        .out_valid_o (tx_fifo_valid),
        .out_ready_i (tx_fifo_pop)
    );

    sample_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (rx_word),
        .in_valid_i  (rx_push),
        .in_ready_o  (rx_fifo_ready),
        .out_data_o  (rx_sample_o),
        .out_valid_o (rx_sample_valid_o),
        .out_ready_i (rx_sample_ready_i)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_clk_prev  <= 1'b0;
            rx_clk_prev  <= 1'b0;
            tx_sync_prev <= 1'b1;
            rx_sync_prev <= 1'b1;
        end else begin
            tx_clk_prev  <= tx_master_clock_i;
            rx_clk_prev  <= rx_master_clock_i;
            tx_sync_prev <= tx_frame_sync_n_i;
            rx_sync_prev <= rx_frame_sync_n_i;
        end
    end

    // Static option pins are registered so the outputs come from flip-flops.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            powered_down_o       <= 1'b0;
            rx_gain_plus3_o      <= 1'b0;
            tx_gain_minus3_o     <= 1'b0;
            tx_filter_bypassed_o <= 1'b0;
        end else begin
            powered_down_o       <= power_down_in_i;
            rx_gain_plus3_o      <= rx_gain_select_i;
            tx_gain_minus3_o     <= tx_gain_select_i && !tx_filter_bypass_i;
            tx_filter_bypassed_o <= tx_filter_bypass_i;
        end
    end

    // Transmit path: arm on sync fall, load at edge A, then one bit per rising edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state        <= pcm_serial_pkg::PATH_IDLE;
            tx_count        <= pcm_serial_pkg::COUNT_RESET;
            tx_word         <= pcm_serial_pkg::IDLE_WORD;
            tx_msb_first    <= 1'b0;
            tx_serial_out_o <= 1'b0;
            tx_serial_oe_o  <= 1'b0;
            tx_underrun_o   <= 1'b0;
        end else begin
            tx_underrun_o <= 1'b0;
            if (power_down_in_i) begin
                tx_state       <= pcm_serial_pkg::PATH_IDLE;
                tx_serial_oe_o <= 1'b0;
            end else begin
                case (tx_state)
                    pcm_serial_pkg::PATH_IDLE: begin
                        tx_serial_oe_o <= 1'b0;
                        if (tx_sync_fall) begin
                            tx_state <= pcm_serial_pkg::PATH_ARMED;
                        end
                    end
                    pcm_serial_pkg::PATH_ARMED: begin
                        if (tx_fall) begin
                            tx_state      <= pcm_serial_pkg::PATH_LOADED;
                            tx_msb_first  <= bit_order_select_i;
                            tx_word       <= tx_fifo_valid ? tx_fifo_data
                                                           : pcm_serial_pkg::IDLE_WORD;
                            tx_underrun_o <= !tx_fifo_valid;
                            tx_count      <= pcm_serial_pkg::COUNT_RESET;
                        end
                    end
                    pcm_serial_pkg::PATH_LOADED: begin
                        if (tx_rise) begin
                            tx_state        <= pcm_serial_pkg::PATH_SHIFT;
                            tx_serial_oe_o  <= 1'b1;
                            tx_serial_out_o <= tx_word[pcm_serial_pkg::bit_pos(tx_count,
                                                                   tx_msb_first)];
                            tx_count        <= tx_count + 5'h01;
                        end
                    end
                    pcm_serial_pkg::PATH_SHIFT: begin
                        if (tx_rise) begin
                            if (tx_count == pcm_serial_pkg::LAST_BIT_COUNT) begin
                                tx_state       <= pcm_serial_pkg::PATH_IDLE;
                                tx_serial_oe_o <= 1'b0;
                            end else begin
                                tx_serial_out_o <= tx_word[pcm_serial_pkg::bit_pos(tx_count,
                                                                       tx_msb_first)];
                                tx_count        <= tx_count + 5'h01;
                            end
                        end
                    end
                    default: begin
                        tx_state <= pcm_serial_pkg::PATH_IDLE;
                    end
                endcase
            end
        end
    end

    always_comb begin
        next_rx_word = rx_word;
        next_rx_word[pcm_serial_pkg::bit_pos(rx_count, rx_msb_first)] = rx_serial_in_i;
    end

    // Receive path: arm on sync fall, edge A starts, then sample on 16 falling edges.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state     <= pcm_serial_pkg::PATH_IDLE;
            rx_count     <= pcm_serial_pkg::COUNT_RESET;
            rx_word      <= pcm_serial_pkg::IDLE_WORD;
            rx_msb_first <= 1'b0;
            rx_push      <= 1'b0;
            rx_overrun_o <= 1'b0;
        end else begin
            rx_push      <= 1'b0;
            rx_overrun_o <= 1'b0;
            if (power_down_in_i) begin
                rx_state <= pcm_serial_pkg::PATH_IDLE;
            end else begin
                case (rx_state)
                    pcm_serial_pkg::PATH_IDLE: begin
                        if (rx_sync_fall) begin
                            rx_state <= pcm_serial_pkg::PATH_ARMED;
                        end
                    end
                    pcm_serial_pkg::PATH_ARMED: begin
                        if (rx_fall) begin
                            rx_state     <= pcm_serial_pkg::PATH_SHIFT;
                            rx_msb_first <= bit_order_select_i;
                            rx_count     <= pcm_serial_pkg::COUNT_RESET;
                        end
                    end
                    pcm_serial_pkg::PATH_SHIFT: begin
                        if (rx_fall) begin
                            rx_word  <= next_rx_word;
                            rx_count <= rx_count + 5'h01;
                            if (rx_count == pcm_serial_pkg::LAST_RX_INDEX) begin
                                rx_state     <= pcm_serial_pkg::PATH_IDLE;
                                rx_push      <= rx_fifo_ready;
                                rx_overrun_o <= !rx_fifo_ready;
                            end
                        end
                    end
                    default: begin
                        rx_state <= pcm_serial_pkg::PATH_IDLE;
                    end
                endcase
            end
        end
    end

    // Counts transmit clock falls between syncs to flag a frame of the wrong length.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_clocks  <= pcm_serial_pkg::FRAME_RESET;
            frame_seen    <= 1'b0;
            frame_error_o <= 1'b0;
        end else begin
            frame_error_o <= 1'b0;
            if (power_down_in_i) begin
                frame_seen   <= 1'b0;
                frame_clocks <= pcm_serial_pkg::FRAME_RESET;
            end else if (tx_sync_fall) begin
                frame_error_o <= frame_seen &&
                                 (frame_clocks != pcm_serial_pkg::FRAME_COUNT_OK);
                frame_seen    <= 1'b1;
                frame_clocks  <= {8'h00, tx_fall};
            end else if (tx_fall && frame_clocks != 9'h1ff) begin
                frame_clocks <= frame_clocks + 9'h001;
            end
        end
    end

    assign tx_active_o = (tx_state != pcm_serial_pkg::PATH_IDLE);
    assign rx_active_o = (rx_state != pcm_serial_pkg::PATH_IDLE);

endmodule
`default_nettype wire

// ---- pcm_serial_port_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcm_serial_port_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_master_clock_i,
    input wire logic tx_frame_sync_n_i,
    input wire logic tx_serial_out_o,
    input wire logic tx_serial_oe_o,
    input wire logic power_down_in_i,
    input wire logic tx_gain_select_i,
    input wire logic tx_filter_bypass_i,
    input wire logic rx_gain_select_i,
    input wire logic rx_gain_plus3_o,
    input wire logic tx_gain_minus3_o,
    input wire logic tx_active_o,
    input wire logic rx_active_o,
    input wire logic rx_sample_valid_o
);
    logic [10:0] oe_cycles;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Counts how many cycles the transmit pin has been driven in a row.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_cycles <= 11'h000;
        end else begin
            oe_cycles <= tx_serial_oe_o ? oe_cycles + 11'h001 : 11'h000;
        end
    end
    property p_oe_idle;
        !tx_active_o && !$past(tx_active_o) |-> !tx_serial_oe_o;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("tx pin driven while idle");
    property p_word_len;
        $fell(tx_serial_oe_o) && !power_down_in_i && !$past(power_down_in_i)
            |-> oe_cycles inside {[11'h3ce:11'h3d2]};
    endproperty
    a_word_len: assert property (p_word_len) else $error("tx word not 16 bit periods");
    property p_oe_on_rise;
        $rose(tx_serial_oe_o) |-> tx_master_clock_i && !$past(tx_master_clock_i, 5);
    endproperty
    a_oe_on_rise: assert property (p_oe_on_rise) else $error("tx drive not after rise");
    property p_bit_on_rise;
        tx_serial_oe_o && $past(tx_serial_oe_o) && $changed(tx_serial_out_o)
            |-> tx_master_clock_i && !$past(tx_master_clock_i, 5);
    endproperty
    a_bit_on_rise: assert property (p_bit_on_rise) else $error("tx bit moved off rise");
    property p_tx_start;
        $fell(tx_frame_sync_n_i) && !tx_active_o && !power_down_in_i |-> ##[0:3] tx_active_o;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("sync fall did not arm tx");
    property p_rx_word;
        $fell(rx_active_o) && !power_down_in_i |-> ##[0:3] rx_sample_valid_o;
    endproperty
    a_rx_word: assert property (p_rx_word) else $error("rx word not delivered");
    property p_power_down;
        power_down_in_i && $past(power_down_in_i) |-> !tx_serial_oe_o && !tx_active_o && !rx_active_o;
    endproperty
    a_power_down: assert property (p_power_down) else $error("active while powered down");
    property p_rx_gain;
        !$past(rst_i) |-> rx_gain_plus3_o == $past(rx_gain_select_i);
    endproperty
    a_rx_gain: assert property (p_rx_gain) else $error("rx gain flag wrong");
    property p_tx_gain;
        !$past(rst_i) |-> tx_gain_minus3_o == $past(tx_gain_select_i && !tx_filter_bypass_i);
    endproperty
    a_tx_gain: assert property (p_tx_gain) else $error("tx gain flag wrong");
    c_tx_word: cover property ($fell(tx_serial_oe_o));
    c_rx_word: cover property ($rose(rx_sample_valid_o));
    c_power_down: cover property (power_down_in_i ##1 power_down_in_i);
endmodule
`default_nettype wire

// ---- pcm_serial_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcm_serial_port_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        msb = 1'b0;
    logic        pd = 1'b0;
    logic        tgain = 1'b0;
    logic        bypass = 1'b0;
    logic        rgain = 1'b0;
    logic        tx_valid = 1'b0;
    logic        rx_ready = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    logic [15:0] rx_word = 16'h8001;
    logic [15:0] txw [4] = '{16'h0001, 16'h8000, 16'h5a3c, 16'hfff1};
    logic [15:0] rxw [4] = '{16'h8001, 16'h1234, 16'hc3a5, 16'h7ffe};
    logic [15:0] rx_data, tx_word;
    logic [7:0]  frames;
    logic        bit_clk, sync_n, rx_line, tx_out, tx_oe, tx_ready, rx_valid, tx_act, rx_act;
    logic        pd_o, rg_o, tg_o, byp_o, underrun, overrun, ferr;
    wire logic   tx_line;
    int          fails, samples_checked, under_seen, over_seen, ferr_seen;
    assign tx_line = tx_oe ? tx_out : 1'bz;
    always #4 clk = ~clk;
    // Both paths share one bit clock and one sync.
    pcm_serial_port i_dut (
        .clk_i(clk), .rst_i(rst), .tx_master_clock_i(bit_clk), .tx_frame_sync_n_i(sync_n),
        .tx_serial_out_o(tx_out), .tx_serial_oe_o(tx_oe), .rx_master_clock_i(bit_clk),
        .rx_frame_sync_n_i(sync_n), .rx_serial_in_i(rx_line), .bit_order_select_i(msb),
        .power_down_in_i(pd), .tx_gain_select_i(tgain), .tx_filter_bypass_i(bypass),
        .rx_gain_select_i(rgain), .tx_sample_i(tx_data), .tx_sample_valid_i(tx_valid),
        .tx_sample_ready_o(tx_ready), .rx_sample_o(rx_data), .rx_sample_valid_o(rx_valid),
        .rx_sample_ready_i(rx_ready), .tx_active_o(tx_act), .rx_active_o(rx_act),
        .powered_down_o(pd_o), .rx_gain_plus3_o(rg_o), .tx_gain_minus3_o(tg_o),
        .tx_filter_bypassed_o(byp_o), .tx_underrun_o(underrun), .rx_overrun_o(overrun),
        .frame_error_o(ferr)
    );
    pcm_partner_model i_partner (
        .msb_first_i(msb), .rx_word_i(rx_word), .tx_line_i(tx_line), .bit_clk_o(bit_clk),
        .sync_n_o(sync_n), .rx_line_o(rx_line), .tx_word_o(tx_word), .frames_o(frames)
    );
    always @(posedge clk) begin
        if (underrun === 1'b1) under_seen++;
        if (overrun === 1'b1) over_seen++;
        if (ferr === 1'b1) ferr_seen++;
    end
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Fills the transmit buffer, then offers one more word that must be refused.
    task automatic fill_tx;
        tx_valid <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            tx_data <= txw[k];
            @(posedge clk);
        end
        tx_data <= 16'hdead;
        @(negedge clk);
        check_bit("tx ready when full", 1'b0, tx_ready);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    task automatic frame(input logic [15:0] exp_tx, input logic next_msb, input logic [15:0] next_rx);
        logic [7:0] seen;
        seen = frames;
        for (int n = 0; n < 20000 && frames == seen; n++) @(posedge clk);
        check_bit("frame done", 1'b1, frames != seen);
        check_word("tx wire word", exp_tx, tx_word);
        msb <= next_msb;
        rx_word <= next_rx;
    endtask
    task automatic drain_rx;
        // The pin is released at the edge that ended the last frame, so look once it settled.
        @(negedge clk);
        check_word("underruns", 16'h0001, 16'(under_seen));
        check_word("overruns", 16'h0001, 16'(over_seen));
        check_word("frame errors", 16'h0000, 16'(ferr_seen));
        check_bit("tx pin idle", 1'bz, tx_line);
        @(posedge clk);
        rx_ready <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            check_word("rx word", rxw[k], rx_data);
            @(posedge clk);
        end
        rx_ready <= 1'b0;
        @(negedge clk);
        check_bit("rx valid after drain", 1'b0, rx_valid);
    endtask
    task automatic pins_check;
        @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            tgain <= k[0];
            rgain <= k[0];
            bypass <= k[1];
            pd <= k[1];
            repeat (3) @(negedge clk);
            check_bit("rx gain", k[0], rg_o);
            check_bit("tx gain", k[0] & ~k[1], tg_o);
            check_bit("filter bypass", k[1], byp_o);
            check_bit("powered down", k[1], pd_o);
            check_bit("tx active", 1'b0, tx_act);
            @(posedge clk);
        end
        pd <= 1'b0;
    endtask
    initial begin
        repeat (19) @(posedge clk);
        @(negedge clk);
        check_bit("tx pin driven in reset", 1'b0, tx_oe);
        check_bit("tx ready in reset", 1'b1, tx_ready);
        check_bit("rx valid in reset", 1'b0, rx_valid);
        @(posedge clk);
        rst <= 1'b0;
        fill_tx;
        frame(txw[0], 1'b1, rxw[1]);
        frame(txw[1], 1'b0, rxw[2]);
        frame(txw[2], 1'b1, rxw[3]);
        frame(txw[3], 1'b0, 16'h0f0f);
        frame(16'h0000, 1'b0, 16'h0f0f);
        drain_rx;
        pins_check;
        test_done;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule
bind pcm_serial_port pcm_serial_port_props i_props (
    .clk_i, .rst_i, .tx_master_clock_i, .tx_frame_sync_n_i, .tx_serial_out_o, .tx_serial_oe_o,
    .power_down_in_i, .tx_gain_select_i, .tx_filter_bypass_i, .rx_gain_select_i,
    .rx_gain_plus3_o, .tx_gain_minus3_o, .tx_active_o, .rx_active_o, .rx_sample_valid_o
);
`default_nettype wire

// ---- sample_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] fill;
    logic             push;
    logic             pop;

    assign in_ready_o  = (fill != CNT_FULL);
    assign out_valid_o = (fill != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
